// [rtl/seq_defs.vh]
// Constants for the acquisition set sequencer: byte offsets, fields,
// encodings and reset values. Definitions only; included by bare name.
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH

// Register byte offsets (one aligned 32-bit word each)
`define OFS_CTRL        6'h00
`define OFS_CMD         6'h04
`define OFS_FEAT_PICK   6'h08
`define OFS_FEAT_ON     6'h0c
`define OFS_SLOT_PICK   6'h10
`define OFS_ROUTE       6'h14
`define OFS_FIRST_SLOT  6'h18
`define OFS_STATUS      6'h1c
`define OFS_LIVE_PICK   6'h20
`define OFS_LIVE_VAL    6'h24
`define OFS_ROUTE_PICK  6'h28

// CTRL fields
`define CTRL_RUN        0
`define CTRL_SETUP      1
// CMD fields (write-one pulses)
`define CMD_STORE       0
`define CMD_RECALL      1
`define CMD_ERASE       2
// ROUTE fields
`define RT_SRC_LO       0
`define RT_EDGE_LO      2
`define RT_NEXT_LO      4
// STATUS fields
`define ST_SETUP_OK     0
`define ST_SLOT_OK      1
`define ST_RUNNING      2
`define ST_SETUP        3
`define ST_CUR_LO       8
`define ST_ALL_OK_LO    16

// Event activation encodings
`define EDGE_RISE       2'h0
`define EDGE_FALL       2'h1
`define EDGE_ANY        2'h2
`define EDGE_NONE       2'h3

// Reset values
`define RST_ROUTE_SRC   2'h0
`define RST_ROUTE_EDGE  2'h0
`define RST_WORD        32'h00000000

`endif

// [rtl/edge_watch.v]
// Edge detector over a vector of event sources.
// Assumes sources are synchronous to the clock.
`timescale 1ns/10ps
module edge_watch #(
  parameter W = 4
) (
  input  wire         core_clk_i,
  input  wire         sys_rst_i,
  input  wire [W-1:0] sig_i,
  output wire [W-1:0] rise_o,
  output wire [W-1:0] fall_o
);
  reg [W-1:0] prev_ff;  // Source levels one cycle ago

  // Remember previous levels
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_ff <= {W{1'b0}};
    end else begin
      prev_ff <= sig_i;
    end
  end

  assign rise_o = sig_i & ~prev_ff;
  assign fall_o = ~sig_i & prev_ff;
endmodule

// [rtl/slot_check.v]
// Validity check of one stored set against the fixed reference values.
// Pure combinational; the caller decides when to sample the result.
`timescale 1ns/10ps
module slot_check #(
  parameter NFEAT = 4,
  parameter VW    = 8
) (
  input  wire [NFEAT*VW-1:0] stored_i,  // Set contents
  input  wire [NFEAT*VW-1:0] ref_i,     // Latest saved fixed values
  input  wire [NFEAT-1:0]    fixed_i,   // Fixed-feature mask
  input  wire                saved_i,   // Set holds data
  output reg                 ok_o
);
  integer k;

  always @* begin
    ok_o = saved_i;
    for (k = 0; k < NFEAT; k = k + 1) begin
      if (fixed_i[k] && (stored_i[k*VW +: VW] != ref_i[k*VW +: VW])) begin
        ok_o = 1'b0;
      end
    end
  end
endmodule

// [rtl/seq_core.v]
// Acquisition set sequencer with an Avalon-MM register slave.
// Assumes event sources are synchronous to core_clk_i.
`timescale 1ns/10ps
`include "seq_defs.vh"
module seq_core #(
  parameter NFEAT     = 4,          // Number of sequencable features
  parameter VW        = 8,          // Width of one feature value
  parameter FIW       = 2,          // Feature index width
  parameter NSLOT     = 8,          // Number of sets
  parameter SIW       = 3,          // Set index width
  parameter NSRC      = 4,          // Event sources (2-bit select)
  parameter IMPLY_MAP = 16'h0021,   // Row j: features implied by j
  parameter FIX_MAP   = 16'h8402,   // Row j: preconditions of j
  parameter AUTO_MASK = 4'h8        // Automatic features to force off
) (
  input  wire                core_clk_i,
  input  wire                sys_rst_i,
  input  wire [5:0]          avs_address_i,
  input  wire                avs_read_i,
  input  wire                avs_write_i,
  input  wire [31:0]         avs_writedata_i,
  input  wire [3:0]          avs_byteenable_i,
  output reg  [31:0]         avs_readdata_o,
  output reg                 avs_waitrequest_o,
  input  wire [NSRC-1:0]     evt_src_i,
  output reg  [NFEAT*VW-1:0] live_cfg_o,
  output reg  [SIW-1:0]      seq_current_slot_o,
  output reg                 running_o
);
  localparam CW = NFEAT*VW;         // Width of one stored set

  // Register state
  reg          seq_run_mode_ff;     // Sequence running
  reg          seq_setup_mode_ff;   // Configuration mode
  reg          seq_setup_ok_ff;     // Overall configuration valid
  reg [FIW-1:0] seq_feature_pick_ff; // Feature addressed by enable
  reg [NFEAT-1:0] seq_feature_on_ff; // Direct feature enables
  reg [SIW-1:0] seq_slot_pick_ff;   // Set addressed by commands
  reg [SIW-1:0] seq_first_slot_ff;  // Starting set
  reg [FIW-1:0] live_pick_ff;       // Feature addressed by LIVE_VAL
  reg [CW-1:0]  live_ff;            // Live configuration
  reg [NFEAT-1:0] dir_ff;           // Direct class
  reg [NFEAT-1:0] imp_ff;           // Implied class
  reg [NFEAT-1:0] fix_ff;           // Fixed class
  reg [NSLOT*CW-1:0] slot_data_ff;  // Stored sets
  reg [CW-1:0]  ref_ff;             // Contents of latest save
  reg [NSLOT-1:0] saved_ff;         // Set holds data
  reg [NSLOT-1:0] seq_slot_ok_ff;   // Per-set validity
  reg           chk_pend_ff;        // Validity refresh pending
  reg [NSLOT*2-1:0] src_ff;         // Event source per route
  reg [NSLOT*2-1:0] edge_ff;        // Activation per route
  reg [NSLOT*SIW-1:0] next_ff;      // Following set per route

  // Bus decode helpers
  wire          acc_go = ~avs_waitrequest_o;
  wire          wr_go  = acc_go & avs_write_i & avs_byteenable_i[0];
  wire [31:0]   wd     = avs_writedata_i;
  wire          wr_ctrl  = wr_go & (avs_address_i == `OFS_CTRL);
  wire          wr_cmd   = wr_go & (avs_address_i == `OFS_CMD);
  wire          do_store = wr_cmd & wd[`CMD_STORE] & seq_setup_mode_ff
                           & ~seq_run_mode_ff;
  wire          do_recall = wr_cmd & wd[`CMD_RECALL]
                            & seq_slot_ok_ff[seq_slot_pick_ff];
  wire          do_erase = wr_cmd & wd[`CMD_ERASE] & ~seq_run_mode_ff;
  wire          run_on   = wr_ctrl & wd[`CTRL_RUN] & ~seq_run_mode_ff
                           & seq_setup_ok_ff & ~seq_setup_mode_ff;
  wire          run_off  = wr_ctrl & ~wd[`CTRL_RUN] & seq_run_mode_ff;
  wire          setup_on = wr_ctrl & wd[`CTRL_SETUP] & ~seq_setup_mode_ff
                           & ~seq_run_mode_ff;
  wire          setup_off = wr_ctrl & ~wd[`CTRL_SETUP] & seq_setup_mode_ff;

  // Class resolution from the enables, sampled at setup entry
  reg [NFEAT-1:0] nxt_imp;
  reg [NFEAT-1:0] nxt_fix;
  integer j;
  always @* begin
    nxt_imp = {NFEAT{1'b0}};
    nxt_fix = {NFEAT{1'b0}};
    for (j = 0; j < NFEAT; j = j + 1) begin
      if (seq_feature_on_ff[j]) begin
        nxt_imp = nxt_imp | IMPLY_MAP[j*NFEAT +: NFEAT];
      end
    end
    nxt_imp = nxt_imp & ~seq_feature_on_ff;
    for (j = 0; j < NFEAT; j = j + 1) begin
      if (seq_feature_on_ff[j] | nxt_imp[j]) begin
        nxt_fix = nxt_fix | FIX_MAP[j*NFEAT +: NFEAT];
      end
    end
    nxt_fix = nxt_fix & ~seq_feature_on_ff & ~nxt_imp;
  end

  // Lock of the addressed live feature
  wire [NFEAT-1:0] seq_mask = dir_ff | imp_ff | fix_ff | AUTO_MASK;
  // fixed locked in setup and run
  wire          live_lock = (fix_ff[live_pick_ff] &
                             (seq_setup_mode_ff | seq_run_mode_ff))
                            | (seq_run_mode_ff & seq_mask[live_pick_ff]);

  // Per-set validity checkers
  wire [NSLOT-1:0] chk_ok;
  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1) begin : g_chk
      // each set rechecked against latest save
      slot_check #(
        .NFEAT (NFEAT),
        .VW    (VW)
      ) u_chk (
        .stored_i (slot_data_ff[g*CW +: CW]),
        .ref_i    (ref_ff),
        .fixed_i  (fix_ff),
        .saved_i  (saved_ff[g]),
        .ok_o     (chk_ok[g])
      );
    end
  endgenerate

  // Overall check: first set valid, every valid set leads to a valid one
  reg     cfg_ok;
  integer s;
  always @* begin
    cfg_ok = seq_slot_ok_ff[seq_first_slot_ff];
    for (s = 0; s < NSLOT; s = s + 1) begin
      if (seq_slot_ok_ff[s] && !seq_slot_ok_ff[next_ff[s*SIW +: SIW]]) begin
        cfg_ok = 1'b0;
      end
    end
  end

  // Event edges for all sources, then pick the current route's source
  wire [NSRC-1:0] rise;
  wire [NSRC-1:0] fall;
  edge_watch #(
    .W (NSRC)
  ) u_edge (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .sig_i      (evt_src_i),
    .rise_o     (rise),
    .fall_o     (fall)
  );
  wire [1:0]     cur_src  = src_ff[seq_current_slot_o*2 +: 2];
  wire [1:0]     cur_edge = edge_ff[seq_current_slot_o*2 +: 2];
  wire [SIW-1:0] cur_next = next_ff[seq_current_slot_o*SIW +: SIW];
  reg            evt_hit;
  always @* begin
    case (cur_edge)
      `EDGE_RISE: evt_hit = rise[cur_src];
      `EDGE_FALL: evt_hit = fall[cur_src];
      `EDGE_ANY:  evt_hit = rise[cur_src] | fall[cur_src];
      default:    evt_hit = 1'b0;
    endcase
  end

  // Bus handshake: one wait cycle, then the access is taken
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (avs_waitrequest_o && (avs_read_i || avs_write_i)) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      // Back to waiting right after the taken edge
      avs_waitrequest_o <= 1'b1;
    end
  end

  // Read data, loaded as waitrequest drops so it stands at the taken edge
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= `RST_WORD;
    end else if (avs_waitrequest_o && avs_read_i) begin
      avs_readdata_o <= `RST_WORD;
      if (avs_address_i == `OFS_CTRL) begin
        avs_readdata_o[`CTRL_RUN]   <= seq_run_mode_ff;
        avs_readdata_o[`CTRL_SETUP] <= seq_setup_mode_ff;
      end else if (avs_address_i == `OFS_FEAT_PICK) begin
        avs_readdata_o[FIW-1:0] <= seq_feature_pick_ff;
      end else if (avs_address_i == `OFS_FEAT_ON) begin
        avs_readdata_o[0] <= seq_feature_on_ff[seq_feature_pick_ff];
      end else if (avs_address_i == `OFS_SLOT_PICK) begin
        avs_readdata_o[SIW-1:0] <= seq_slot_pick_ff;
      end else if (avs_address_i == `OFS_ROUTE) begin
        avs_readdata_o[`RT_SRC_LO +: 2] <= src_ff[seq_slot_pick_ff*2 +: 2];
        avs_readdata_o[`RT_EDGE_LO +: 2] <= edge_ff[seq_slot_pick_ff*2 +: 2];
        avs_readdata_o[`RT_NEXT_LO +: SIW] <=
          next_ff[seq_slot_pick_ff*SIW +: SIW];
      end else if (avs_address_i == `OFS_FIRST_SLOT) begin
        avs_readdata_o[SIW-1:0] <= seq_first_slot_ff;
      end else if (avs_address_i == `OFS_STATUS) begin
        avs_readdata_o[`ST_SETUP_OK] <= seq_setup_ok_ff;
        avs_readdata_o[`ST_SLOT_OK]  <= seq_slot_ok_ff[seq_slot_pick_ff];
        avs_readdata_o[`ST_RUNNING]  <= seq_run_mode_ff;
        avs_readdata_o[`ST_SETUP]    <= seq_setup_mode_ff;
        avs_readdata_o[`ST_CUR_LO +: SIW] <= seq_current_slot_o;
        avs_readdata_o[`ST_ALL_OK_LO +: NSLOT] <= seq_slot_ok_ff;
      end else if (avs_address_i == `OFS_LIVE_PICK) begin
        avs_readdata_o[FIW-1:0] <= live_pick_ff;
      end else if (avs_address_i == `OFS_LIVE_VAL) begin
        avs_readdata_o[VW-1:0] <= live_ff[live_pick_ff*VW +: VW];
      end
      // Unmapped, CMD and ROUTE_PICK read as zero
    end
  end

  // Mode control, classes and selectors
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      seq_run_mode_ff     <= 1'b0;
      seq_setup_mode_ff   <= 1'b0;
      seq_setup_ok_ff     <= 1'b0;
      seq_feature_pick_ff <= {FIW{1'b0}};
      seq_feature_on_ff   <= {NFEAT{1'b0}};
      seq_slot_pick_ff    <= {SIW{1'b0}};
      seq_first_slot_ff   <= {SIW{1'b0}};
      live_pick_ff        <= {FIW{1'b0}};
      dir_ff              <= {NFEAT{1'b0}};
      imp_ff              <= {NFEAT{1'b0}};
      fix_ff              <= {NFEAT{1'b0}};
    end else begin
      if (setup_on) begin
        seq_setup_mode_ff <= 1'b1;
        seq_setup_ok_ff   <= 1'b0;
        dir_ff <= seq_feature_on_ff;
        imp_ff <= nxt_imp;
        fix_ff <= nxt_fix;
      end else if (setup_off) begin
        seq_setup_mode_ff <= 1'b0;
        seq_setup_ok_ff   <= cfg_ok;
      end
      if (do_erase) begin
        seq_setup_ok_ff <= 1'b0;
      end
      // start only from a valid, idle state
      if (run_on) begin
        seq_run_mode_ff <= 1'b1;
      end else if (run_off) begin
        seq_run_mode_ff <= 1'b0;
      end
      if (wr_go && avs_address_i == `OFS_FEAT_PICK) begin
        seq_feature_pick_ff <= wd[FIW-1:0];
      end
      // one enable per feature, shared by all sets
      if (wr_go && avs_address_i == `OFS_FEAT_ON &&
          !seq_setup_mode_ff && !seq_run_mode_ff) begin
        seq_feature_on_ff[seq_feature_pick_ff] <= wd[0];
      end
      // eight sets behind the slot pick
      if (wr_go && avs_address_i == `OFS_SLOT_PICK) begin
        seq_slot_pick_ff <= wd[SIW-1:0];
      end
      if (wr_go && avs_address_i == `OFS_FIRST_SLOT &&
          !seq_run_mode_ff) begin
        seq_first_slot_ff <= wd[SIW-1:0];
      end
      if (wr_go && avs_address_i == `OFS_LIVE_PICK) begin
        live_pick_ff <= wd[FIW-1:0];
      end
    end
  end

  // Routes, one per set
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_ff  <= {NSLOT{`RST_ROUTE_SRC}};
      edge_ff <= {NSLOT{`RST_ROUTE_EDGE}};
      next_ff <= {NSLOT*SIW{1'b0}};
    end else if (wr_go && avs_address_i == `OFS_ROUTE &&
                 !seq_run_mode_ff) begin
      // route of the set at the slot pick, no route index applied
      src_ff[seq_slot_pick_ff*2 +: 2]  <= wd[`RT_SRC_LO +: 2];
      edge_ff[seq_slot_pick_ff*2 +: 2] <= wd[`RT_EDGE_LO +: 2];
      next_ff[seq_slot_pick_ff*SIW +: SIW] <= wd[`RT_NEXT_LO +: SIW];
    end
  end

  // Set storage and validity
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slot_data_ff   <= {NSLOT*CW{1'b0}};
      ref_ff         <= {CW{1'b0}};
      saved_ff       <= {NSLOT{1'b0}};
      seq_slot_ok_ff <= {NSLOT{1'b0}};
      chk_pend_ff    <= 1'b0;
    end else begin
      chk_pend_ff <= do_store;
      if (do_erase) begin
        saved_ff       <= {NSLOT{1'b0}};
        seq_slot_ok_ff <= {NSLOT{1'b0}};
      end else if (do_store) begin
        slot_data_ff[seq_slot_pick_ff*CW +: CW] <= live_ff;
        ref_ff <= live_ff;
        saved_ff[seq_slot_pick_ff] <= 1'b1;
      end else if (chk_pend_ff) begin
        seq_slot_ok_ff <= chk_ok;
      end
    end
  end

  // Live configuration and sequence stepping
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      live_ff            <= {CW{1'b0}};
      seq_current_slot_o <= {SIW{1'b0}};
    end else if (run_on) begin
      live_ff            <= slot_data_ff[seq_first_slot_ff*CW +: CW];
      seq_current_slot_o <= seq_first_slot_ff;
    end else if (seq_run_mode_ff && !run_off && evt_hit) begin
      live_ff            <= slot_data_ff[cur_next*CW +: CW];
      seq_current_slot_o <= cur_next;
    end else if (do_recall) begin
      live_ff <= slot_data_ff[seq_slot_pick_ff*CW +: CW];
    end else if (wr_go && avs_address_i == `OFS_LIVE_VAL && !live_lock) begin
      live_ff[live_pick_ff*VW +: VW] <= wd[VW-1:0];
    end
  end

  // Outputs; forced features read as manual (zero) while running
  integer f;
  always @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      live_cfg_o <= {CW{1'b0}};
      running_o  <= 1'b0;
    end else begin
      running_o <= seq_run_mode_ff;
      for (f = 0; f < NFEAT; f = f + 1) begin
        if (seq_run_mode_ff && AUTO_MASK[f]) begin
          live_cfg_o[f*VW +: VW] <= {VW{1'b0}};
        end else begin
          live_cfg_o[f*VW +: VW] <= live_ff[f*VW +: VW];
        end
      end
    end
  end
endmodule

// [verification/seq_core_monitor.sv]
// Checker for seq_core: bus handshake timing and run-state behaviour.
// Sees only the top ports; bound into every seq_core at the foot.
`timescale 1ns/10ps
module seq_core_monitor #(
  parameter NFEAT = 4,
  parameter VW    = 8,
  parameter SIW   = 3,
  parameter NSRC  = 4
) (
  input wire                core_clk_i,
  input wire                sys_rst_i,
  input wire [5:0]          avs_address_i,
  input wire                avs_read_i,
  input wire                avs_write_i,
  input wire [31:0]         avs_writedata_i,
  input wire [3:0]          avs_byteenable_i,
  input wire [31:0]         avs_readdata_o,
  input wire                avs_waitrequest_o,
  input wire [NSRC-1:0]     evt_src_i,
  input wire [NFEAT*VW-1:0] live_cfg_o,
  input wire [SIW-1:0]      seq_current_slot_o,
  input wire                running_o
);
  // Write accepted this edge; only such a write may start or stop a run
  wire wr_taken = avs_write_i && !avs_waitrequest_o;
  // Single clock domain
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_wait_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("wait low for more than one cycle");
  property p_wait_cause;
    !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i);
  endproperty
  a_wait_cause: assert property (p_wait_cause)
    else $error("answer without a request");
  // A pending access is answered within one or two cycles
  property p_answer;
    (avs_read_i || avs_write_i) && avs_waitrequest_o
      |-> ##[1:2] !avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("access not answered in time");
  property p_rd_hold;
    avs_waitrequest_o |-> $stable(avs_readdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved between reads");
  // Top feature is the automatic one; it reads manual while running
  property p_forced;
    running_o |-> live_cfg_o[NFEAT*VW-1 -: VW] == {VW{1'b0}};
  endproperty
  a_forced: assert property (p_forced)
    else $error("automatic feature not forced while running");
  property p_step_cause;
    running_o && $past(running_o) && $changed(seq_current_slot_o)
      |-> $past(evt_src_i) != $past(evt_src_i, 2);
  endproperty
  a_step_cause: assert property (p_step_cause)
    else $error("set changed with no source edge");
  // Outside a run only the run start may move the current set
  property p_idle_hold;
    !running_o && $changed(seq_current_slot_o) |=> running_o;
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("current set moved while stopped");
  property p_run_src;
    $rose(running_o) |-> $past(wr_taken, 2);
  endproperty
  a_run_src: assert property (p_run_src)
    else $error("run began without a write");
  property p_stop_src;
    $fell(running_o) |-> $past(wr_taken, 2);
  endproperty
  a_stop_src: assert property (p_stop_src)
    else $error("run ended without a write");
  c_start: cover property ($rose(running_o));
  c_step: cover property (running_o && $changed(seq_current_slot_o));
  c_stop: cover property ($fell(running_o));
endmodule
bind seq_core seq_core_monitor #(
  .NFEAT(NFEAT), .VW(VW), .SIW(SIW), .NSRC(NSRC)
) u_seq_core_monitor (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .evt_src_i(evt_src_i),
  .live_cfg_o(live_cfg_o), .seq_current_slot_o(seq_current_slot_o),
  .running_o(running_o)
);

// [verification/bus_host.sv]
// Host model: Avalon-MM master that software uses to reach the sequencer.
// Assumes the slave shares its clock; one call at a time.
`timescale 1ns/10ps
module bus_host (
  input  wire        core_clk_i,
  input  wire [31:0] avs_readdata_i,
  input  wire        avs_waitrequest_i,
  output reg  [5:0]  avs_address_o,
  output reg         avs_read_o,
  output reg         avs_write_o,
  output reg  [31:0] avs_writedata_o,
  output wire [3:0]  avs_byteenable_o
);
  // Writable fields sit in byte 0 but STATUS reaches byte 2, so every lane stays enabled
  assign avs_byteenable_o = 4'hf;
  initial begin
    avs_address_o = 6'h00;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h00000000;
  end
  // Request held until waitrequest is seen low at an edge
  task wr(input [5:0] a, input [31:0] v);
    begin
      @(posedge core_clk_i);
      avs_address_o <= a;
      avs_writedata_o <= v;
      avs_write_o <= 1'b1;
      @(posedge core_clk_i);
      while (avs_waitrequest_i)
        @(posedge core_clk_i);
      avs_write_o <= 1'b0;
      // Released data no longer means anything
      avs_writedata_o <= ~v;
    end
  endtask
  // Data taken at the same edge that ends the wait
  task rd(input [5:0] a, output [31:0] v);
    begin
      @(posedge core_clk_i);
      avs_address_o <= a;
      avs_read_o <= 1'b1;
      @(posedge core_clk_i);
      while (avs_waitrequest_i)
        @(posedge core_clk_i);
      v = avs_readdata_i;
      avs_read_o <= 1'b0;
    end
  endtask
endmodule

// [verification/tb_seq_core.sv]
// Self-checking bench for seq_core: host bus model plus event sources.
// Assumes the seq_core register map and its one-wait-cycle bus slave.
`timescale 1ns/10ps
`include "seq_defs.vh"
module tb_seq_core;
  reg         core_clk_i;
  reg         sys_rst_i;
  reg  [3:0]  evt;
  wire [5:0]  adr;
  wire        rd_s;
  wire        wr_s;
  wire [31:0] wdat;
  wire [3:0]  ben;
  wire [31:0] rdat;
  wire        wreq;
  wire [31:0] live;
  wire [2:0]  cur;
  wire        run;
  integer     n_errors;
  integer     checks_done;
  integer     m;
  integer     s;
  reg  [31:0] d;
  // Feature 0 implies feature 2, so the implied class is not empty
  seq_core #(
    .IMPLY_MAP (16'h0004)
  ) u_seq_core (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr),
    .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
    .avs_byteenable_i(ben), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .evt_src_i(evt), .live_cfg_o(live),
    .seq_current_slot_o(cur), .running_o(run));
  bus_host u_bus_host (
    .core_clk_i(core_clk_i), .avs_readdata_i(rdat),
    .avs_waitrequest_i(wreq), .avs_address_o(adr), .avs_read_o(rd_s),
    .avs_write_o(wr_s), .avs_writedata_o(wdat), .avs_byteenable_o(ben));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  task wr(input [5:0] a, input [31:0] v);
    u_bus_host.wr(a, v);
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  // Read, keep only the fields of interest, compare
  task rchk(input [5:0] a, input [31:0] msk, input [31:0] e);
    begin
      u_bus_host.rd(a, d);
      chk(d & msk, e);
    end
  endtask
  task lv(input [1:0] k, input [7:0] v);
    begin
      wr(`OFS_LIVE_PICK, {30'h0, k});
      wr(`OFS_LIVE_VAL, {24'h0, v});
    end
  endtask
  // Route first, then contents: rising edge on source 0
  task cfg_slot(input [2:0] sl, input [2:0] nx);
    begin
      wr(`OFS_SLOT_PICK, {29'h0, sl});
      wr(`OFS_ROUTE, {25'h0, nx, 4'h0});
      rchk(`OFS_ROUTE, 32'h7f, {25'h0, nx, 4'h0});
      lv(2'h0, 8'h50 + sl);
      wr(`OFS_CMD, 32'h1);
      rchk(`OFS_STATUS, 32'h2, 32'h2);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_errors = n_errors + 1;
    close_out;
  end
  initial begin
    sys_rst_i = 1'b1;
    evt = 4'h0;
    n_errors = 0;
    checks_done = 0;
    repeat (2) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rchk(`OFS_STATUS, 32'hffffffff, 32'h0);
    wr(6'h2c, 32'hffffffff);
    rchk(6'h2c, 32'hffffffff, 32'h0);
    wr(`OFS_ROUTE_PICK, 32'hff);
    rchk(`OFS_ROUTE_PICK, 32'hff, 32'h0);
    wr(`OFS_FIRST_SLOT, 32'hff);
    rchk(`OFS_FIRST_SLOT, 32'hff, 32'h7);
    wr(`OFS_CTRL, 32'h1);
    rchk(`OFS_CTRL, 32'h3, 32'h0);
    $display("test map_and_reset done");
    wr(`OFS_FEAT_PICK, 32'h0);
    wr(`OFS_FEAT_ON, 32'h1);
    lv(2'h0, 8'h11);
    lv(2'h1, 8'h22);
    lv(2'h2, 8'h33);
    lv(2'h3, 8'h44);
    wr(`OFS_CTRL, 32'h2);
    wr(`OFS_FEAT_ON, 32'h0);
    rchk(`OFS_FEAT_ON, 32'h1, 32'h1);
    lv(2'h1, 8'h99);
    rchk(`OFS_LIVE_VAL, 32'hff, 32'h22);
    lv(2'h2, 8'h3c);
    rchk(`OFS_LIVE_VAL, 32'hff, 32'h3c);
    lv(2'h2, 8'h33);
    for (s = 0; s < 2; s = s + 1)
      cfg_slot(s[2:0], s[2:0] ^ 3'h1);
    rchk(`OFS_STATUS, 32'hff0000, 32'h30000);
    wr(`OFS_CTRL, 32'h0);
    lv(2'h1, 8'h23);
    wr(`OFS_CTRL, 32'h2);
    cfg_slot(3'h2, 3'h0);
    rchk(`OFS_STATUS, 32'hff0000, 32'h40000);
    for (s = 0; s < 2; s = s + 1)
      cfg_slot(s[2:0], s[2:0] ^ 3'h1);
    rchk(`OFS_STATUS, 32'hff0000, 32'h70000);
    wr(`OFS_FIRST_SLOT, 32'h1);
    wr(`OFS_CTRL, 32'h0);
    rchk(`OFS_STATUS, 32'h1, 32'h1);
    $display("test setup done");
    // Set 1 routes to set 0 on source m with edge mode m; mode 3 never steps
    wr(`OFS_SLOT_PICK, 32'h1);
    for (m = 0; m < 4; m = m + 1) begin
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_ROUTE, {28'h0, m[1:0], m[1:0]});
      wr(`OFS_CTRL, 32'h1);
      repeat (2) @(posedge core_clk_i);
      chk({run, 5'h0, cur}, 9'h101);
      chk(live, 32'h00332351);
      lv(2'h2, 8'hee);
      chk(live[23:16], 8'h33);
      evt[m] <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      evt[m] <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      chk({cur, live[7:0]}, (m == 3) ? 11'h151 : 11'h050);
    end
    $display("test event_modes done");
    wr(`OFS_CTRL, 32'h0);
    repeat (2) @(posedge core_clk_i);
    chk({run, cur}, 4'h1);
    chk(live, 32'h44332351);
    wr(`OFS_SLOT_PICK, 32'h0);
    wr(`OFS_CMD, 32'h2);
    repeat (2) @(posedge core_clk_i);
    chk(live[7:0], 8'h50);
    wr(`OFS_CMD, 32'h4);
    rchk(`OFS_STATUS, 32'hff0001, 32'h0);
    $display("test stop_recall_erase done");
    close_out;
  end
endmodule
